// file: logic/wdt_top.v
// Purpose: watchdog counter with NMI / system reset, freeze, Avalon-MM regs
// Assumes: 20 MHz CORE_CLK, RESETN is the system reset (async, active low)
// Notes:   reset request output is expected to loop back to RESETN
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_top
#(
   parameter [`WDT_PRE_W-1:0] TICK_CYCLES = `WDT_TICK_CYCLES
)
(
   // clock, reset, enable
   input  wire        CORE_CLK,
   input  wire        RESETN,
   input  wire        CLK_EN,
   // avalon-mm slave
   input  wire [4:0]  AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   input  wire [3:0]  AVS_BYTEENABLE,
   output reg  [31:0] AVS_READDATA,
   output reg         AVS_WAITREQUEST,
   // debug halt from the core
   input  wire        DEBUG_HALTED,
   // outputs to core and reset controller
   output reg         NMI,
   output reg         DOG_SYSTEM_RESET,
   output reg         IRQ
);
   wire        tick;
   reg  [8:0]  count;
   reg         reset_only;
   reg         dog_freeze_bit;
   reg  [`WDT_EV_W-1:0] irq_stat;
   reg  [`WDT_EV_W-1:0] irq_mask;
   reg         served;

   reg  [8:0]  next_count;
   reg  [`WDT_EV_W-1:0] next_stat;
   reg  [31:0] rdata;
   reg         hit_nmi;
   reg         hit_rst;

   // five address bits so all seven word registers are reachable
   wire [2:0]  idx = AVS_ADDRESS[4:2];
   wire        req = (AVS_READ | AVS_WRITE) & ~served;
   wire        wr  = AVS_WRITE & ~served & CLK_EN;
   wire        rd  = AVS_READ & ~served & CLK_EN;
   wire        frozen = DEBUG_HALTED | dog_freeze_bit; // [RULE_08]

   // signed compare of the 9-bit counter against a limit
   function le_signed;
      input [8:0] a;
      input [8:0] b;
      begin
         le_signed = ($signed(a) <= $signed(b));
      end
   endfunction

   wdt_prescaler #(.PERIOD(TICK_CYCLES)) u_pre
   (
      .core_clk (CORE_CLK),
      .resetn   (RESETN),
      .clk_en   (CLK_EN),
      .tick     (tick)
   );

   // counter next value and event detection
   always @*
   begin
      next_count = count;
      if (wr && idx == `WDT_IDX_COUNT && AVS_BYTEENABLE[1:0] == 2'h3
          && !AVS_WRITEDATA[`WDT_WLOCK_BIT]) // [RULE_03]
         next_count = {1'b0, AVS_WRITEDATA[7:0]}; // [RULE_13]
      else if (tick && !frozen && count != `WDT_NEG_LIMIT) // [RULE_01]
         next_count = count - 9'h001; // [RULE_04]
      hit_nmi = !reset_only && count != 9'h000
                && next_count == 9'h000; // [RULE_05]
      if (reset_only)
         hit_rst = le_signed(next_count, 9'h000); // [RULE_07]
      else
         hit_rst = le_signed(next_count, `WDT_NEG_LIMIT); // [RULE_05]
   end

   // sticky status: hardware set beats same-cycle write-one clear
   always @*
   begin
      next_stat = irq_stat;
      if (wr && idx == `WDT_IDX_IRQ_STAT && AVS_BYTEENABLE[0])
         next_stat = irq_stat & ~AVS_WRITEDATA[`WDT_EV_W-1:0];
      if (hit_nmi)
         next_stat[`WDT_EV_NMI] = 1'b1;
      if (hit_rst)
         next_stat[`WDT_EV_RST] = 1'b1;
      if (tick && !frozen)
         next_stat[`WDT_EV_TICK] = 1'b1;
   end

   // read mux
   always @*
   begin
      rdata = 32'h0000_0000;
      case (idx)
         `WDT_IDX_COUNT:    rdata[8:0] = count;
         `WDT_IDX_CTRL:     rdata[`WDT_RSTONLY_BIT] = reset_only;
         `WDT_IDX_FRZ_SET:  rdata[`WDT_FRZ_BIT] = dog_freeze_bit;
         `WDT_IDX_FRZ_CLR:  rdata[`WDT_FRZ_BIT] = dog_freeze_bit;
         `WDT_IDX_STATUS:   rdata[1:0] = {DEBUG_HALTED, frozen};
         `WDT_IDX_IRQ_STAT: rdata[`WDT_EV_W-1:0] = irq_stat;
         `WDT_IDX_IRQ_MASK: rdata[`WDT_EV_W-1:0] = irq_mask;
         default:           rdata = 32'h0000_0000;
      endcase
   end

   // bus handshake: waitrequest drops one cycle after the request
   always @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h0000_0000;
         served          <= 1'b0;
      end
      else if (CLK_EN)
      begin
         served          <= req;
         AVS_WAITREQUEST <= ~req;
         if (rd)
            AVS_READDATA <= rdata;
      end
   end

   // watchdog state; RESETN is the system reset, so count returns to 255
   always @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         count            <= `WDT_COUNT_RESET; // [RULE_02]
         reset_only       <= 1'b0;
         dog_freeze_bit   <= 1'b0;
         irq_stat         <= {`WDT_EV_W{1'b0}};
         irq_mask         <= {`WDT_EV_W{1'b0}};
         NMI              <= 1'b0;
         DOG_SYSTEM_RESET <= 1'b0;
         IRQ              <= 1'b0;
      end
      else if (CLK_EN)
      begin
         count    <= next_count;
         irq_stat <= next_stat;
         IRQ      <= |(next_stat & irq_mask);
         // nmi is a single pulse per zero crossing
         NMI      <= hit_nmi;
         // held until the reset controller asserts RESETN low
         if (hit_rst)
            DOG_SYSTEM_RESET <= 1'b1;
         if (wr && AVS_BYTEENABLE[0])
         begin
            if (idx == `WDT_IDX_CTRL && AVS_WRITEDATA[`WDT_RSTONLY_BIT])
               reset_only <= 1'b1; // [RULE_11]
            if (idx == `WDT_IDX_FRZ_SET && AVS_WRITEDATA[`WDT_FRZ_BIT]
                && !reset_only)
               dog_freeze_bit <= 1'b1; // [RULE_09]
            if (idx == `WDT_IDX_FRZ_CLR && AVS_WRITEDATA[`WDT_FRZ_BIT])
               dog_freeze_bit <= 1'b0; // [RULE_10]
            if (idx == `WDT_IDX_IRQ_MASK)
               irq_mask <= AVS_WRITEDATA[`WDT_EV_W-1:0];
         end
         // reset-only mode cannot stay frozen by software
         if (reset_only)
            dog_freeze_bit <= 1'b0; // [RULE_09]
      end
   end
endmodule
`default_nettype wire

// file: logic/wdt_regs.vh
// Purpose: constants for the watchdog block (offsets, fields, resets, timing)
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, 20 MHz clock
// Notes:   included by both design files
//
// Behaviour
// [RULE_01] Counter decrements by one every 10.24 ms tick unless frozen.
// [RULE_02] Any system reset, watchdog-caused too, sets the counter to 255.
// [RULE_03] Counter writes are taken only when the written write-lock bit is 0.
// [RULE_04] Past zero the counter goes negative via bit 8: 1, 0, 1FF down to 1F0.
// [RULE_05] Reset-only clear: NMI at zero, system reset at or below -16.
// [RULE_06] Handler must rewrite above -16 within about 16 ticks after NMI.
// [RULE_07] Reset-only set: system reset at or below zero, no NMI.
// [RULE_08] Debug halt always stops decrementing; software cannot mask it.
// [RULE_09] Freeze-set write of 1 freezes, only while reset-only is clear.
// [RULE_10] Freeze-clear write of 1 unfreezes; counting resumes from held value.
// [RULE_11] Reset-only bit is set by software, cleared only by system reset.
// [RULE_12] Software order: freeze, select mode, write reload, then unfreeze.
// [RULE_13] Tick from free-running prescaler; writes win over same-cycle decrement.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// register byte addresses (word aligned)
`define WDT_ADDR_COUNT     5'h00
`define WDT_ADDR_CTRL      5'h04
`define WDT_ADDR_FRZ_SET   5'h08
`define WDT_ADDR_FRZ_CLR   5'h0c
`define WDT_ADDR_STATUS    5'h10
`define WDT_ADDR_IRQ_STAT  5'h14
`define WDT_ADDR_IRQ_MASK  5'h18
// word index = byte address [4:2]
`define WDT_IDX_COUNT      3'h0
`define WDT_IDX_CTRL       3'h1
`define WDT_IDX_FRZ_SET    3'h2
`define WDT_IDX_FRZ_CLR    3'h3
`define WDT_IDX_STATUS     3'h4
`define WDT_IDX_IRQ_STAT   3'h5
`define WDT_IDX_IRQ_MASK   3'h6

// count register fields
`define WDT_VAL_MSB        8
`define WDT_WLOCK_BIT      9
// control register field
`define WDT_RSTONLY_BIT    0
// freeze set/clear field
`define WDT_FRZ_BIT        0
// interrupt status/mask fields
`define WDT_EV_NMI         0
`define WDT_EV_RST         1
`define WDT_EV_TICK        2
`define WDT_EV_W           3

// reset value and negative limit
`define WDT_COUNT_RESET    9'h0ff
`define WDT_NEG_LIMIT      9'h1f0

// timing
`define WDT_CLK_HZ         20000000
`define WDT_TICK_NS        10240000
`define WDT_CLK_NS         50
// tick period over clock period, sized to the prescaler width
`define WDT_TICK_CYCLES    18'd204800
`define WDT_PRE_W          18

`endif

// file: logic/wdt_prescaler.v
// Purpose: free-running divider producing the one-cycle watchdog tick
// Assumes: synchronous clock enable, asynchronous active-low reset
// Notes:   period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_prescaler
#(
   parameter [`WDT_PRE_W-1:0] PERIOD = `WDT_TICK_CYCLES
)
(
   // clock and reset
   input  wire core_clk,
   input  wire resetn,
   input  wire clk_en,
   // tick out
   output reg  tick
);
   reg [`WDT_PRE_W-1:0] cnt;

   // free running: freeze does not stop it, so resume keeps phase
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt  <= {`WDT_PRE_W{1'b0}};
         tick <= 1'b0;
      end
      else if (clk_en)
      begin
         if (cnt == PERIOD - 1'b1)
         begin
            cnt  <= {`WDT_PRE_W{1'b0}};
            tick <= 1'b1; // [RULE_13]
         end
         else
         begin
            cnt  <= cnt + 1'b1;
            tick <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: verif/wdt_assertions.sv
// Purpose: port checks on the watchdog
// Assumes: one clock, RESETN active low
// Notes:   bound to wdt_top
`timescale 1ns/1ps
`default_nettype none
module wdt_checker (
   // clock, reset
   input wire logic        CORE_CLK,
   input wire logic        RESETN,
   input wire logic        CLK_EN,
   // bus
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   // core side
   input wire logic        DEBUG_HALTED,
   input wire logic        NMI,
   input wire logic        DOG_SYSTEM_RESET,
   input wire logic        IRQ
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);
   a_nmi_pulse: assert property (NMI |=> !NMI)
      else $error("nmi wider than one cycle");
   a_reset_sticky: assert property (DOG_SYSTEM_RESET |=> DOG_SYSTEM_RESET)
      else $error("reset request dropped");
   a_nmi_no_reset: assert property (NMI |-> !DOG_SYSTEM_RESET)
      else $error("nmi with reset");
   a_reset_gap: assert property ($rose(NMI) |=> !DOG_SYSTEM_RESET [*8])
      else $error("reset too soon after nmi");
   a_halt_freeze: assert property ((DEBUG_HALTED && !AVS_WRITE) [*4]
      |-> !$rose(NMI))
      else $error("nmi while halted");
   a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && CLK_EN
      && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("no answer next cycle");
   a_rdata_hold: assert property (!AVS_READ |-> $stable(AVS_READDATA))
      else $error("read data moved");
   a_reset_values: assert property (disable iff (1'b0) !RESETN
      |-> AVS_WAITREQUEST && !NMI && !DOG_SYSTEM_RESET && !IRQ)
      else $error("outputs not cleared");
endmodule
bind wdt_top wdt_checker chk (.CORE_CLK, .RESETN, .CLK_EN, .AVS_READ,
   .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .DEBUG_HALTED, .NMI,
   .DOG_SYSTEM_RESET, .IRQ);
`default_nettype wire

// file: verif/wdt_core_model.sv
// Purpose: core and reset controller facing the watchdog
// Assumes: reset request loops back as a short system reset
// Notes:   counts nmi pulses for the bench
`timescale 1ns/1ps
`default_nettype none
module wdt_core_model (
   // clock, bench reset
   input  wire logic core_clk,
   input  wire logic bench_resetn,
   // from the watchdog
   input  wire logic nmi,
   input  wire logic sys_rst,
   // to watchdog and bench
   output logic      resetn,
   output var int    nmi_count
);
   logic [1:0] hold = 2'h0;
   initial nmi_count = 0;
   always @(posedge core_clk)
   begin
      hold <= sys_rst ? 2'h3 : hold - {1'b0, hold != 2'h0};
      if (nmi)
         nmi_count <= nmi_count + 1;
   end
   // watchdog reset is a full system reset
   assign resetn = bench_resetn & (hold == 2'h0);
endmodule
`default_nettype wire

// file: verif/tb_watchdog_nmi_reset_timer.sv
// Purpose: self-checking bench for the watchdog
// Assumes: tick shortened to 8 cycles
// Notes:   core model loops the reset back
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_nmi_reset_timer;
   localparam int TK = 8;
   logic        clk = 1'b0;
   logic        brst_n = 1'b1;
   logic        halt = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic        cen = 1'b1;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] got;
   wire         resetn, waitreq, nmi, srst, irq;
   wire  [31:0] rdat;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          nmi_count;
   int          n;
   wdt_top #(.TICK_CYCLES(18'd8)) dut (.CORE_CLK(clk), .RESETN(resetn),
      .CLK_EN(cen), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(waitreq), .DEBUG_HALTED(halt), .NMI(nmi),
      .DOG_SYSTEM_RESET(srst), .IRQ(irq));
   wdt_core_model core (.core_clk(clk), .bench_resetn(brst_n), .nmi(nmi),
      .sys_rst(srst), .resetn(resetn), .nmi_count(nmi_count));
   always #25 clk = ~clk;
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (waitreq !== 1'b0 && k < 50);
      got = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
      cmp({31'h0, k < 50}, 32'h1);
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp(got, e);
   endtask
   // waits on nmi (sel 0) or the reset request (sel 1)
   task automatic waitfor(input logic sel, input int lim);
      n = 0;
      while ((sel ? srst : nmi) !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      cmp({31'h0, n < lim}, 32'h1);
   endtask
   task give_verdict;
      $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      give_verdict;
   end
   initial
   begin
      brst_n <= 1'b0;
      repeat (4) @(posedge clk);
      brst_n <= 1'b1;
      @(posedge clk);
      // enable low holds prescaler too, else ticks would have passed
      cen <= 1'b0;
      repeat (3 * TK) @(posedge clk);
      cen <= 1'b1;
      rdchk(5'h00, 32'h0ff);
      halt <= 1'b1;
      bus(1'b1, 5'h00, 32'h3ff);
      rdchk(5'h00, 32'h0ff);
      bus(1'b1, 5'h00, 32'h003);
      repeat (3 * TK) @(posedge clk);
      rdchk(5'h00, 32'h003);
      bus(1'b1, 5'h08, 32'h1);
      halt <= 1'b0;
      repeat (3 * TK) @(posedge clk);
      rdchk(5'h00, 32'h003);
      bus(1'b1, 5'h0c, 32'h1);
      waitfor(1'b0, 4 * TK);
      // handler reload above -16: a second nmi, no reset yet
      bus(1'b1, 5'h00, 32'h001);
      waitfor(1'b0, 2 * TK);
      waitfor(1'b1, 18 * TK);
      cmp({31'h0, n >= 16 * TK - 2 && n <= 16 * TK + 2}, 32'h1);
      cmp({31'h0, irq}, 32'h0);
      repeat (5) @(posedge clk);
      rdchk(5'h00, 32'h0ff);
      bus(1'b1, 5'h04, 32'h1);
      bus(1'b1, 5'h04, 32'h0);
      rdchk(5'h04, 32'h1);
      bus(1'b1, 5'h08, 32'h1);
      bus(1'b1, 5'h00, 32'h002);
      waitfor(1'b1, 3 * TK);
      cmp(nmi_count, 32'h2);
      repeat (5) @(posedge clk);
      rdchk(5'h04, 32'h0);
      // tick event through the mask to the irq line, then cleared
      bus(1'b1, 5'h18, 32'h4);
      repeat (TK) @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      halt <= 1'b1;
      bus(1'b1, 5'h14, 32'h7);
      rdchk(5'h14, 32'h0);
      rdchk(5'h10, 32'h3);
      cmp({31'h0, irq}, 32'h0);
      give_verdict;
   end
endmodule
`default_nettype wire
